//--- design/nims_irq_ctrl.sv
// interrupt mask and status registers of the network controller
//
// Contract
// [RULE1] mask bit 7 lets a timer wrap from zero to all ones interrupt
// [RULE2] mask bit 6 lets receive descriptors exhausted interrupt
// [RULE3] mask bit 5 lets receive resources exhausted interrupt
// [RULE4] mask bit 4 lets receive buffer area overflow interrupt
// [RULE5] mask bit 3 lets crc tally wrap to zero interrupt
// [RULE6] mask bit 2 lets alignment tally wrap to zero interrupt
// [RULE7] mask bit 1 lets missed packet tally wrap to zero interrupt
// [RULE8] mask bit 0 lets receive fifo overrun interrupt
// [RULE9] status reaches the pin only through its mask bit
// [RULE10] writing one clears a status bit, writing zero does nothing
// [RULE11] status clears on hardware reset, survives software reset
// [RULE12] bit 14 marks bus retry; latched mode: master only, dma held
// [RULE13] unlatched mode resumes dma without waiting for the clear
// [RULE14] bit 13 marks missing heartbeat within 6.4 us after transmit
// [RULE15] bit 12 marks address filter load finished
// [RULE16] bit 11 marks programmed interrupt flag seen in tx config
// [RULE17] bit 10 marks packet received after sequence field written
// [RULE18] bit 9 marks list end, halt, or transmit abort
// [RULE19] transmit done bit set only after tx status field written
// [RULE20] mask clears on hardware reset, each one bit enables
// [RULE21] pin active whenever status and mask share a set bit
`default_nettype none
module nims_irq_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  // software reset leaves both registers alone
  input wire logic soft_reset,
  // register port
  input wire logic [nims_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [nims_pkg::REG_DATA_W-1:0] reg_wdata,
  output logic [nims_pkg::REG_DATA_W-1:0] reg_rdata,
  // bus retry
  input wire logic bus_retry_input,
  input wire logic bus_master,
  input wire logic latched_retry_mode,
  output logic dma_hold,
  // transmit side
  input wire logic tx_end,
  input wire logic col_heartbeat_pin,
  input wire logic tx_config_read,
  input wire logic programmed_irq_bit,
  input wire logic end_of_list_flag,
  input wire logic halt_tx_cmd,
  input wire logic byte_count_mismatch,
  input wire logic too_many_collisions,
  input wire logic tx_fifo_underrun,
  input wire logic too_much_deferral,
  input wire logic tx_status_written,
  // receive side and filter
  input wire logic filter_load_done,
  input wire logic rx_seq_written,
  input wire logic rx_desc_exhausted,
  input wire logic rx_res_exhausted,
  input wire logic rx_buf_overflow,
  input wire logic rx_fifo_overrun,
  // counters
  input wire logic timer_step,
  input wire logic [nims_pkg::TIMER_W-1:0] timer_value,
  input wire logic crc_tally_step,
  input wire logic [nims_pkg::TALLY_W-1:0] crc_tally_value,
  input wire logic align_tally_step,
  input wire logic [nims_pkg::TALLY_W-1:0] align_tally_value,
  input wire logic missed_tally_step,
  input wire logic [nims_pkg::TALLY_W-1:0] missed_tally_value,
  // interrupt pin
  output logic irq
);
  import nims_pkg::*;

  logic [15:0] irq_status_reg_r;
  logic [15:0] irq_status_reg_nxt;
  logic [15:0] irq_enable_reg_r;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic status_wr;
  logic mask_wr;
  logic col_meta_r;
  logic col_sync_r;
  logic hb_lost;
  logic timer_wrap;
  logic crc_wrap;
  logic align_wrap;
  logic missed_wrap;
  logic tx_done_pend_r;
  logic tx_fault_pend_r;
  logic tx_abort;
  logic tx_done_cause;
  logic retry_set;
  logic soft_reset_seen_r;

  ////////////////////////////////////////////////////////////////////////
  // address decode
  assign status_wr = reg_wr & (reg_addr == STATUS_ADDR);
  assign mask_wr = reg_wr & (reg_addr == MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // heartbeat pin arrives from the transceiver, so it is synchronised
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      col_meta_r <= 1'b0;
      col_sync_r <= 1'b0;
    end else begin
      col_meta_r <= col_heartbeat_pin;
      col_sync_r <= col_meta_r;
    end
  end

  // [RULE14] heartbeat window
  nims_heartbeat_mon u_hb (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tx_end(tx_end),
    .col_seen(col_sync_r),
    .hb_lost(hb_lost)
  );

  ////////////////////////////////////////////////////////////////////////
  // counter wrap detection
  // [RULE1] timer wraps downward
  nims_wrap_detect #(
    .WIDTH(TIMER_W),
    .COUNT_DOWN(1'b1)
  ) u_timer_wrap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(timer_step),
    .value(timer_value),
    .wrap(timer_wrap)
  );

  // [RULE5] crc tally wrap
  nims_wrap_detect #(
    .WIDTH(TALLY_W),
    .COUNT_DOWN(1'b0)
  ) u_crc_wrap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(crc_tally_step),
    .value(crc_tally_value),
    .wrap(crc_wrap)
  );

  // [RULE6] alignment tally wrap
  nims_wrap_detect #(
    .WIDTH(TALLY_W),
    .COUNT_DOWN(1'b0)
  ) u_align_wrap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(align_tally_step),
    .value(align_tally_value),
    .wrap(align_wrap)
  );

  // [RULE7] missed packet tally wrap
  nims_wrap_detect #(
    .WIDTH(TALLY_W),
    .COUNT_DOWN(1'b0)
  ) u_missed_wrap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .step(missed_tally_step),
    .value(missed_tally_value),
    .wrap(missed_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit completion waits for the descriptor status write
  assign tx_abort = byte_count_mismatch | too_many_collisions |
                    tx_fifo_underrun | too_much_deferral;
  // [RULE18] done causes
  assign tx_done_cause = end_of_list_flag | halt_tx_cmd | tx_abort;

  // [RULE19] hold cause until status written
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_done_pend_r <= 1'b0;
      tx_fault_pend_r <= 1'b0;
    end else if (tx_status_written) begin
      tx_done_pend_r <= 1'b0;
      tx_fault_pend_r <= 1'b0;
    end else begin
      tx_done_pend_r <= tx_done_pend_r | tx_done_cause;
      tx_fault_pend_r <= tx_fault_pend_r | tx_abort;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event vector
  // [RULE12] latched mode sets only as master
  assign retry_set = bus_retry_input & (bus_master | ~latched_retry_mode);

  always_comb begin
    set_vec = 16'h0000;
    set_vec[BUS_RETRY_BIT] = retry_set;
    set_vec[HEARTBEAT_BIT] = hb_lost;
    // [RULE15] filter load done
    set_vec[FILTER_DONE_BIT] = filter_load_done;
    // [RULE16] programmed interrupt
    set_vec[PROG_IRQ_BIT] = tx_config_read & programmed_irq_bit;
    // [RULE17] packet received
    set_vec[PKT_IN_BIT] = rx_seq_written;
    // [RULE19] done after status write
    set_vec[TX_DONE_BIT] = tx_status_written & (tx_done_pend_r | tx_done_cause);
    set_vec[TX_FAULT_BIT] = tx_status_written & (tx_fault_pend_r | tx_abort);
    set_vec[TIMER_WRAP_BIT] = timer_wrap;
    // [RULE2] descriptors exhausted
    set_vec[DESC_EMPTY_BIT] = rx_desc_exhausted;
    // [RULE3] resources exhausted
    set_vec[RES_EMPTY_BIT] = rx_res_exhausted;
    // [RULE4] buffer area exceeded
    set_vec[BUF_OVF_BIT] = rx_buf_overflow;
    set_vec[CRC_TALLY_BIT] = crc_wrap;
    set_vec[ALIGN_TALLY_BIT] = align_wrap;
    set_vec[MISSED_TALLY_BIT] = missed_wrap;
    // [RULE8] fifo overrun
    set_vec[RX_OVERRUN_BIT] = rx_fifo_overrun;
  end

  // [RULE10] write one to clear
  assign clr_vec = status_wr ? (reg_wdata & IMPL_BITS) : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // status bits: a set in the clearing cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_status
      always_comb begin
        irq_status_reg_nxt[gi] = IMPL_BITS[gi] &
          (set_vec[gi] | (irq_status_reg_r[gi] & ~clr_vec[gi]));
      end
    end
  endgenerate

  // [RULE11] hardware reset only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status_reg_r <= STATUS_RESET;
    end else begin
      irq_status_reg_r <= irq_status_reg_nxt;
    end
  end

  // [RULE20] mask register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_enable_reg_r <= MASK_RESET;
    end else if (mask_wr) begin
      irq_enable_reg_r <= reg_wdata & IMPL_BITS;
    end
  end

  // software reset is accepted but changes neither register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      soft_reset_seen_r <= 1'b0;
    end else begin
      soft_reset_seen_r <= soft_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        STATUS_ADDR: reg_rdata <= irq_status_reg_r;
        MASK_ADDR: reg_rdata <= irq_enable_reg_r;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // [RULE12] latched retry holds dma until cleared
  // [RULE13] unlatched mode never holds
  assign dma_hold = latched_retry_mode & irq_status_reg_r[BUS_RETRY_BIT];

  // [RULE9] masked contribution
  // [RULE21] pin from status and mask
  // soft reset has no say here, so a pending interrupt survives it
  assign irq = |(irq_status_reg_r & irq_enable_reg_r);
endmodule : nims_irq_ctrl
`default_nettype wire

//--- common/nims_pkg.sv
// constants shared by the interrupt mask and status block
`default_nettype none
package nims_pkg;
  // register port
  localparam int REG_ADDR_W = 6;
  localparam int REG_DATA_W = 16;
  localparam logic [5:0] MASK_ADDR = 6'h04;
  localparam logic [5:0] STATUS_ADDR = 6'h05;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // bit 15 is fixed at zero in both registers
  localparam logic [15:0] IMPL_BITS = 16'h7fff;
  // status / mask bit positions
  localparam int BUS_RETRY_BIT = 14;
  localparam int HEARTBEAT_BIT = 13;
  localparam int FILTER_DONE_BIT = 12;
  localparam int PROG_IRQ_BIT = 11;
  localparam int PKT_IN_BIT = 10;
  localparam int TX_DONE_BIT = 9;
  localparam int TX_FAULT_BIT = 8;
  localparam int TIMER_WRAP_BIT = 7;
  localparam int DESC_EMPTY_BIT = 6;
  localparam int RES_EMPTY_BIT = 5;
  localparam int BUF_OVF_BIT = 4;
  localparam int CRC_TALLY_BIT = 3;
  localparam int ALIGN_TALLY_BIT = 2;
  localparam int MISSED_TALLY_BIT = 1;
  localparam int RX_OVERRUN_BIT = 0;
  // counter widths
  localparam int TIMER_W = 32;
  localparam int TALLY_W = 16;
  // heartbeat window
  localparam int CLK_PERIOD_PS = 25000;
  localparam int HB_WINDOW_PS = 6400000;
  localparam int HB_WINDOW_CYC = (HB_WINDOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HB_CNT_W = 9;
  localparam logic [8:0] HB_WINDOW_LAST = 9'(HB_WINDOW_CYC - 1);
  typedef enum logic [1:0] {
    NIMS_HB_IDLE = 2'b00,
    NIMS_HB_WATCH = 2'b01
  } nims_hb_e;
endpackage : nims_pkg
`default_nettype wire

//--- design/nims_wrap_detect.sv
// one-cycle pulse when a counter wraps on its next step
`default_nettype none
module nims_wrap_detect #(
  parameter int WIDTH = 16,
  parameter bit COUNT_DOWN = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [WIDTH-1:0] value,
  output logic wrap
);
  import nims_pkg::*;

  logic edge_val;

  ////////////////////////////////////////////////////////////////////////
  // up counters wrap from all ones, down counters from all zeros
  assign edge_val = COUNT_DOWN ? (value == '0) : (value == '1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrap <= 1'b0;
    end else begin
      wrap <= step & edge_val;
    end
  end
endmodule : nims_wrap_detect
`default_nettype wire

//--- design/nims_heartbeat_mon.sv
// watches for the collision heartbeat after each transmission
`default_nettype none
module nims_heartbeat_mon (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tx_end,
  input wire logic col_seen,
  output logic hb_lost
);
  import nims_pkg::*;

  nims_hb_e state_r;
  logic [HB_CNT_W-1:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // [RULE14] heartbeat window check
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= NIMS_HB_IDLE;
      cnt_r <= '0;
      hb_lost <= 1'b0;
    end else begin
      hb_lost <= 1'b0;
      unique case (state_r)
        NIMS_HB_IDLE: begin
          if (tx_end) begin
            state_r <= NIMS_HB_WATCH;
            cnt_r <= '0;
          end
        end
        NIMS_HB_WATCH: begin
          if (col_seen) begin
            state_r <= NIMS_HB_IDLE;
          end else if (cnt_r == HB_WINDOW_LAST) begin
            state_r <= NIMS_HB_IDLE;
            hb_lost <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 9'h001;
          end
        end
      endcase
    end
  end
endmodule : nims_heartbeat_mon
`default_nettype wire

//--- sim/nims_irq_ctrl_chk.sv
// assertions on the ports of the interrupt mask and status block
`default_nettype none
module nims_irq_ctrl_chk
  import nims_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [nims_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [nims_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic [nims_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic bus_retry_input,
  input wire logic bus_master,
  input wire logic latched_retry_mode,
  input wire logic dma_hold,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence rd_stat;
    reg_rd && reg_addr == STATUS_ADDR;
  endsequence
  sequence mask_full;
    reg_wr && reg_addr == MASK_ADDR && reg_wdata == 16'h7fff;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  rst_zero_a: assert property (
    $rose(rst_n) |-> !irq && !dma_hold && reg_rdata == 16'h0000)
    else $error("state not cleared by reset");
  irq_read_a: assert property (rd_stat ##0 irq |=> reg_rdata != 16'h0000)
    else $error("irq active while status reads zero");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq dropped without a write");
  mask_off_a: assert property (
    reg_wr && reg_addr == MASK_ADDR && reg_wdata == 16'h0000 |=> !irq)
    else $error("irq active with mask all zero");
  // status cannot shrink without a status write, so the read value still stands
  mask_on_a: assert property (
    rd_stat ##0 !reg_wr ##1 mask_full ##0 reg_rdata != 16'h0000 |=> irq)
    else $error("irq inactive with masked status set");
  dma_mode_a: assert property (dma_hold |-> latched_retry_mode)
    else $error("dma held outside latched retry mode");
  dma_cause_a: assert property ($rose(dma_hold) |->
    $past(bus_retry_input && bus_master) || $rose(latched_retry_mode))
    else $error("dma hold without retry as master");
  dma_keep_a: assert property (
    dma_hold && !reg_wr |=> dma_hold || !latched_retry_mode)
    else $error("dma hold released without a clear");
endmodule // nims_irq_ctrl_chk
bind nims_irq_ctrl nims_irq_ctrl_chk nims_irq_ctrl_chk_inst (.*);
`default_nettype wire

//--- sim/tb_nims_irq_ctrl.sv
// self-checking testbench for the interrupt mask and status block
`default_nettype none
module tb_nims_irq_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import nims_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic bus_master = 1'b0, latched_retry_mode = 1'b0, col_heartbeat_pin = 1'b0;
  logic programmed_irq_bit = 1'b0, dma_hold, irq;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [REG_DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [TIMER_W-1:0] timer_value = 32'h00000001;
  logic [TALLY_W-1:0] crc_tally_value = '0, align_tally_value = '0, missed_tally_value = '0;
  // pulse index equals the status bit it sets, where there is one
  logic [20:0] p = '0;
  wire logic too_much_deferral, tx_fifo_underrun, too_many_collisions, byte_count_mismatch;
  wire logic halt_tx_cmd, end_of_list_flag, bus_retry_input, tx_end, filter_load_done;
  wire logic tx_config_read, rx_seq_written, tx_status_written, soft_reset, timer_step;
  wire logic rx_desc_exhausted, rx_res_exhausted, rx_buf_overflow, crc_tally_step;
  wire logic align_tally_step, missed_tally_step, rx_fifo_overrun;
  assign {too_much_deferral, tx_fifo_underrun, too_many_collisions, byte_count_mismatch,
    halt_tx_cmd, end_of_list_flag, bus_retry_input, tx_end, filter_load_done,
    tx_config_read, rx_seq_written, tx_status_written, soft_reset, timer_step,
    rx_desc_exhausted, rx_res_exhausted, rx_buf_overflow, crc_tally_step,
    align_tally_step, missed_tally_step, rx_fifo_overrun} = p;
  logic [31:0] s = 32'h00004bed;
  int errors = 0, total_checks = 0;
  int dl[7] = '{0, 4, 5, 6, 10, 11, 12};
  int wl[4] = '{7, 3, 2, 1};

  nims_irq_ctrl nims_irq_ctrl_inst (.*);

  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function logic [15:0] tx_exp(int k);
    // the last four causes are aborts and flag a fault too
    return (k < 17) ? 16'h0200 : 16'h0300;
  endfunction
  task end_sim();
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp16(logic [15:0] g, logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t read %h expected %h", $time, g, e);
    end
  endtask
  task cmp1(logic g, logic e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t pin %b expected %b", $time, g, e);
    end
  endtask
  task tick();
    @(posedge ref_clk);
    #2;
  endtask
  // strobes stay as set until the next call, so every sequence ends idle
  task bus(logic w, logic r, logic [REG_ADDR_W-1:0] a, logic [15:0] v);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = v;
    tick();
  endtask
  task wr(logic [REG_ADDR_W-1:0] a, logic [15:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, v);
  endtask
  task pulse(int k);
    p = 21'h000001 << k;
    tick();
    p = '0;
    tick();
  endtask
  task expect_st(logic [15:0] e);
    logic [15:0] m;
    m = s[3] ? 16'h7fff : 16'(rnd()) & 16'h7fff;
    bus(1'b0, 1'b1, STATUS_ADDR, 16'h0000);
    cmp16(reg_rdata, e);
    bus(1'b1, 1'b0, MASK_ADDR, m);
    cmp1(irq, |(e & m));
    bus(1'b1, 1'b0, STATUS_ADDR, 16'(rnd()) & ~e);
    bus(1'b0, 1'b1, STATUS_ADDR, 16'h0000);
    cmp16(reg_rdata, e);
    bus(1'b1, 1'b0, STATUS_ADDR, e);
    bus(1'b0, 1'b1, STATUS_ADDR, 16'h0000);
    cmp16(reg_rdata, 16'h0000);
    bus(1'b0, 1'b0, STATUS_ADDR, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    bus(1'b0, 1'b1, MASK_ADDR, 16'h0000);
    cmp16(reg_rdata, MASK_RESET);
    bus(1'b0, 1'b1, 6'h3f, 16'h0000);
    cmp16(reg_rdata, 16'h0000);
    expect_st(STATUS_RESET);
    programmed_irq_bit = 1'b1;
    foreach (dl[i]) begin
      pulse(dl[i]);
      expect_st(16'h0001 << dl[i]);
    end
    programmed_irq_bit = 1'b0;
    pulse(11);
    expect_st(16'h0000);
    foreach (wl[i]) for (int w = 0; w < 2; w++) begin
      timer_value = w ? 32'h00000000 : rnd() | 32'h00000001;
      crc_tally_value = w ? 16'hffff : 16'(rnd()) & 16'hfffe;
      align_tally_value = crc_tally_value;
      missed_tally_value = crc_tally_value;
      pulse(wl[i]);
      tick();
      expect_st(w ? 16'h0001 << wl[i] : 16'h0000);
    end
    for (int k = 15; k < 21; k++) begin
      pulse(k);
      expect_st(16'h0000);
      pulse(9);
      expect_st(tx_exp(k));
      pulse(9);
      expect_st(16'h0000);
    end
    latched_retry_mode = 1'b1;
    pulse(14);
    cmp1(dma_hold, 1'b0);
    expect_st(16'h0000);
    bus_master = 1'b1;
    pulse(14);
    cmp1(dma_hold, 1'b1);
    expect_st(16'h4000);
    cmp1(dma_hold, 1'b0);
    latched_retry_mode = 1'b0;
    pulse(14);
    cmp1(dma_hold, 1'b0);
    expect_st(16'h4000);
    pulse(13);
    repeat (300) tick();
    expect_st(16'h2000);
    pulse(13);
    repeat (50) tick();
    col_heartbeat_pin = 1'b1;
    repeat (4) tick();
    col_heartbeat_pin = 1'b0;
    repeat (300) tick();
    expect_st(16'h0000);
    pulse(0);
    wr(MASK_ADDR, 16'h0001);
    pulse(8);
    cmp1(irq, 1'b1);
    wr(MASK_ADDR, 16'h0000);
    cmp1(irq, 1'b0);
    wr(MASK_ADDR, 16'h7fff);
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    cmp1(irq, 1'b0);
    bus(1'b0, 1'b1, MASK_ADDR, 16'h0000);
    cmp16(reg_rdata, MASK_RESET);
    expect_st(STATUS_RESET);
    end_sim();
  end
endmodule // tb_nims_irq_ctrl
`default_nettype wire
